// >>> hdl/igoe_pkg.sv
package igoe_pkg;

  // Four logic blocks, four global clock pins, six dedicated inputs.
  localparam int NUM_BLOCKS = 4;
  localparam int NUM_CLK_PINS = 4;
  localparam int NUM_LOCAL_CLKS = 4;
  localparam int NUM_DED_IN = 6;
  localparam int NUM_GOE = 4;
  localparam int NUM_GOE_SMALL = 2;
  localparam int PINS_PER_BLOCK = 8;

  // Oscillator and divider.
  localparam int OSC_NOMINAL_HZ = 5000000;
  localparam int CLK_SYS_HZ = 125000000;
  localparam logic [31:0] OSC_TICK_CYCLES = 32'(CLK_SYS_HZ / OSC_NOMINAL_HZ);
  localparam logic [31:0] DIV_FACTOR_DEFAULT = 32'h0010_0000;
  localparam logic [31:0] DIV_FACTOR_SMALL = 32'h0000_0400;

  // AXI4-Lite register byte offsets.
  localparam logic [7:0] REG_CLK_SEL = 8'h00;
  localparam logic [7:0] REG_GUARD_CFG = 8'h04;
  localparam logic [7:0] REG_PIN_BYPASS = 8'h08;
  localparam logic [7:0] REG_GOE_CFG = 8'h0C;
  localparam logic [7:0] REG_OSC_CFG = 8'h10;
  localparam logic [7:0] REG_DIV_FACTOR = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_DED_GUARD = 8'h1C;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_SEL = 32'h3210_3210;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-block guard configuration: enable source selection.
  typedef struct packed {
    logic [NUM_BLOCKS-1:0] src_ext;
    logic [NUM_BLOCKS-1:0] guard_en;
  } igoe_guard_cfg_t;

  // Oscillator control bundle.
  typedef struct packed {
    logic osc_en;
    logic dyn_dis_en;
    logic div_rst_en;
    logic [1:0] fb_sel;
  } igoe_osc_cfg_t;

endpackage

// >>> hdl/igoe_clk_gen.sv
// Forms four local clocks for one logic block from the global clock pins.
module igoe_clk_gen (
  input wire logic [igoe_pkg::NUM_CLK_PINS-1:0] gclk_i,
  input wire logic [15:0] sel_i,
  output logic [igoe_pkg::NUM_LOCAL_CLKS-1:0] lclk_o
);

  // Each local clock takes a 2-bit pin pick plus an inversion bit.
  always_comb begin
    for (int k = 0; k < igoe_pkg::NUM_LOCAL_CLKS; k++) begin
      lclk_o[k] = gclk_i[sel_i[4*k +: 2]] ^ sel_i[4*k+2];
    end
  end

endmodule

// >>> hdl/igoe_top.sv
// Functional notes
// - Every logic block has a generator producing four local clocks.
// - Each local clock picks a global clock pin, true or inverted.
// - Four global clock pins, each also forwarded to the routing pool.
// - All pins of one block share one block input enable.
// - Block input enable comes from macrocell logic or an external pin.
// - Each pin may be set to ignore the block input enable.
// - Guard blocks and enables equal the logic block count, four here.
// - Dedicated inputs and clocks are optionally guarded by an assigned block.
// - Clock inputs 0 to 3 are guarded by blocks A, B, C, D.
// - Dedicated inputs 0 to 5 are guarded by A, B, B, C, D, D.
// - Global output enable bus is four bits, two in the smallest size.
// - Global enable bus comes from four product terms plus two pins.
// - Every source of the global enable bus can be inverted.
// - Each block's enable term fuses onto every internal bus bit.
// - Oscillator outputs drive routing lines; macrocells drive reset, disable.
// - Two macrocell feedbacks select macrocell or oscillator signals.
// - Divider output is the 5 MHz oscillator divided by the factor.
// - Oscillator stops while its disable input is asserted.
module igoe_top (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and fabric.
  input wire logic [igoe_pkg::NUM_CLK_PINS-1:0] gclk_pin_i,
  input wire logic [igoe_pkg::NUM_BLOCKS*igoe_pkg::PINS_PER_BLOCK-1:0] io_pin_i,
  input wire logic [igoe_pkg::NUM_DED_IN-1:0] ded_in_i,
  input wire logic [igoe_pkg::NUM_BLOCKS-1:0] bie_macrocell_i,
  input wire logic [igoe_pkg::NUM_BLOCKS-1:0] bie_ext_pin_i,
  input wire logic [igoe_pkg::NUM_BLOCKS-1:0] oe_product_term_i,
  input wire logic [1:0] goe_pin_i,
  input wire logic [1:0] macrocell_fb_i,
  input wire logic divider_reset_in_i,
  input wire logic osc_dynamic_disable_i,
  output logic [igoe_pkg::NUM_BLOCKS*igoe_pkg::NUM_LOCAL_CLKS-1:0] logic_block_clk_o,
  output logic [igoe_pkg::NUM_CLK_PINS-1:0] routing_clk_o,
  output logic [igoe_pkg::NUM_BLOCKS*igoe_pkg::PINS_PER_BLOCK-1:0] routing_pin_o,
  output logic [igoe_pkg::NUM_DED_IN-1:0] routing_ded_o,
  output logic [igoe_pkg::NUM_GOE-1:0] global_output_enable_o,
  output logic osc_clock_out_o,
  output logic divided_clock_out_o,
  output logic [1:0] macrocell_fb_o
);

  localparam int NB = igoe_pkg::NUM_BLOCKS;
  localparam int NP = igoe_pkg::PINS_PER_BLOCK;

  // Configuration registers.
  logic [31:0] clk_sel_q;
  igoe_pkg::igoe_guard_cfg_t guard_cfg_q;
  logic [NB*NP-1:0] pin_bypass_q;
  logic [31:0] goe_cfg_q;
  igoe_pkg::igoe_osc_cfg_t osc_cfg_q;
  logic [31:0] div_factor_q;
  logic [15:0] ded_guard_q;

  // Pin synchronisers: two flops before any logic.
  logic [NB*NP-1:0] pin_s1_q, pin_s2_q;
  logic [igoe_pkg::NUM_CLK_PINS-1:0] clk_s1_q, clk_s2_q;
  logic [igoe_pkg::NUM_DED_IN-1:0] ded_s1_q, ded_s2_q;
  logic [NB-1:0] bext_s1_q, bext_s2_q;
  logic [1:0] goep_s1_q, goep_s2_q;
  logic dis_s1_q, dis_s2_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      clk_s1_q <= '0;
      clk_s2_q <= '0;
      ded_s1_q <= '0;
      ded_s2_q <= '0;
      bext_s1_q <= '0;
      bext_s2_q <= '0;
      goep_s1_q <= '0;
      goep_s2_q <= '0;
      dis_s1_q <= 1'b0;
      dis_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= io_pin_i;
      pin_s2_q <= pin_s1_q;
      clk_s1_q <= gclk_pin_i;
      clk_s2_q <= clk_s1_q;
      ded_s1_q <= ded_in_i;
      ded_s2_q <= ded_s1_q;
      bext_s1_q <= bie_ext_pin_i;
      bext_s2_q <= bext_s1_q;
      goep_s1_q <= goe_pin_i;
      goep_s2_q <= goep_s1_q;
      dis_s1_q <= osc_dynamic_disable_i;
      dis_s2_q <= dis_s1_q;
    end
  end

  // Local clock generators, one per logic block; blocks A and C use clk_sel[15:0], blocks B and D use clk_sel[31:16].
  for (genvar b = 0; b < NB; b++) begin : g_clkgen
    igoe_clk_gen u_clk_gen (
      .gclk_i(clk_s2_q),
      .sel_i((b % 2 == 1) ? clk_sel_q[31:16] : clk_sel_q[15:0]),
      .lclk_o(logic_block_clk_o[b*4 +: 4])
    );
  end

  // Block input enable per block: macrocell or external source.
  logic [NB-1:0] block_input_enable;
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      block_input_enable[b] = guard_cfg_q.src_ext[b] ? bext_s2_q[b]
                                                     : bie_macrocell_i[b];
    end
  end

  // Guarded pins hold their last value while the block enable is off.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      routing_pin_o <= '0;
    end else begin
      for (int i = 0; i < NB*NP; i++) begin
        if (pin_bypass_q[i] || !guard_cfg_q.guard_en[i/NP]
            || block_input_enable[i/NP]) begin
          routing_pin_o[i] <= pin_s2_q[i];
        end
      end
    end
  end

  // Dedicated clocks map to blocks A..D, dedicated inputs to A,B,B,C,D,D.
  localparam logic [7:0] CLK_MAP = 8'hE4;
  localparam logic [11:0] DED_MAP = 12'hF94;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      routing_clk_o <= '0;
      routing_ded_o <= '0;
    end else begin
      for (int c = 0; c < igoe_pkg::NUM_CLK_PINS; c++) begin
        if (!ded_guard_q[c] || block_input_enable[CLK_MAP[2*c +: 2]]) begin
          routing_clk_o[c] <= clk_s2_q[c];
        end
      end
      for (int d = 0; d < igoe_pkg::NUM_DED_IN; d++) begin
        if (!ded_guard_q[4+d] || block_input_enable[DED_MAP[2*d +: 2]]) begin
          routing_ded_o[d] <= ded_s2_q[d];
        end
      end
    end
  end

  // Global output enables: fused OR of block terms, plus two pins, invertible.
  // goe_cfg: [15:0] fuses, [19:16] term invert, [21:20] pin invert,
  // [23:22] pin select for bits 0 and 1, [26] small two-bit bus mode.
  logic [3:0] goe_term_bus;
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      goe_term_bus[g] = 1'b0;
      for (int b = 0; b < NB; b++) begin
        goe_term_bus[g] = goe_term_bus[g]
                          | (oe_product_term_i[b] & goe_cfg_q[b*4+g]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      global_output_enable_o <= '0;
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (g < 2 && goe_cfg_q[22+g]) begin
          global_output_enable_o[g] <= goep_s2_q[g] ^ goe_cfg_q[20+g];
        end else if (goe_cfg_q[26] && g >= igoe_pkg::NUM_GOE_SMALL) begin
          global_output_enable_o[g] <= 1'b0;
        end else begin
          global_output_enable_o[g] <= goe_term_bus[g] ^ goe_cfg_q[16+g];
        end
      end
    end
  end

  // Oscillator: toggles at the nominal rate, stops when disabled.
  logic [31:0] osc_cnt_q;
  logic [31:0] div_cnt_q;
  logic osc_stop;
  logic osc_tick;
  assign osc_stop = !osc_cfg_q.osc_en
                    || (osc_cfg_q.dyn_dis_en && dis_s2_q);
  assign osc_tick = (osc_cnt_q == (igoe_pkg::OSC_TICK_CYCLES >> 1) - 32'h1);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_cnt_q <= '0;
      osc_clock_out_o <= 1'b0;
    end else if (osc_stop) begin
      osc_cnt_q <= '0;
    end else if (osc_tick) begin
      osc_cnt_q <= '0;
      osc_clock_out_o <= !osc_clock_out_o;
    end else begin
      osc_cnt_q <= osc_cnt_q + 32'h1;
    end
  end

  // Divider counts oscillator rising edges; output toggles each half factor.
  logic osc_rise;
  assign osc_rise = osc_tick && !osc_stop && !osc_clock_out_o;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_q <= '0;
      divided_clock_out_o <= 1'b0;
    end else if (osc_cfg_q.div_rst_en && divider_reset_in_i) begin
      div_cnt_q <= '0;
      divided_clock_out_o <= 1'b0;
    end else if (osc_rise) begin
      if (div_cnt_q >= (div_factor_q >> 1) - 32'h1) begin
        div_cnt_q <= '0;
        divided_clock_out_o <= !divided_clock_out_o;
      end else begin
        div_cnt_q <= div_cnt_q + 32'h1;
      end
    end
  end

  // Feedback multiplexers on two macrocells.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      macrocell_fb_o <= '0;
    end else begin
      macrocell_fb_o[0] <= osc_cfg_q.fb_sel[0] ? osc_clock_out_o
                                               : macrocell_fb_i[0];
      macrocell_fb_o[1] <= osc_cfg_q.fb_sel[1] ? divided_clock_out_o
                                               : macrocell_fb_i[1];
    end
  end

  // AXI4-Lite write path: address and data latched in either order.
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_ok;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign wr_fire = aw_hold_q && w_hold_q;
  always_comb begin
    case (aw_addr_q)
      igoe_pkg::REG_CLK_SEL, igoe_pkg::REG_GUARD_CFG, igoe_pkg::REG_PIN_BYPASS,
      igoe_pkg::REG_GOE_CFG, igoe_pkg::REG_OSC_CFG, igoe_pkg::REG_DIV_FACTOR,
      igoe_pkg::REG_DED_GUARD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= igoe_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? igoe_pkg::RESP_OKAY : igoe_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores.
  logic [31:0] guard_word, osc_word;
  assign guard_word = {24'h0, guard_cfg_q};
  assign osc_word = {27'h0, osc_cfg_q};
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_sel_q <= igoe_pkg::RST_CLK_SEL;
      guard_cfg_q <= '0;
      pin_bypass_q <= '0;
      goe_cfg_q <= igoe_pkg::RST_ZERO;
      osc_cfg_q <= '0;
      div_factor_q <= igoe_pkg::DIV_FACTOR_DEFAULT;
      ded_guard_q <= '0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        igoe_pkg::REG_CLK_SEL: clk_sel_q <= merge(clk_sel_q, w_data_q, w_strb_q);
        igoe_pkg::REG_GUARD_CFG: guard_cfg_q <= 8'(merge(guard_word, w_data_q, w_strb_q));
        igoe_pkg::REG_PIN_BYPASS: pin_bypass_q <= merge(pin_bypass_q, w_data_q, w_strb_q);
        igoe_pkg::REG_GOE_CFG: goe_cfg_q <= merge(goe_cfg_q, w_data_q, w_strb_q);
        igoe_pkg::REG_OSC_CFG: osc_cfg_q <= 5'(merge(osc_word, w_data_q, w_strb_q));
        igoe_pkg::REG_DIV_FACTOR: div_factor_q <= merge(div_factor_q, w_data_q, w_strb_q);
        igoe_pkg::REG_DED_GUARD: begin
          ded_guard_q <= 16'(merge({16'h0, ded_guard_q}, w_data_q, w_strb_q));
        end
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path: one cycle to answer.
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      igoe_pkg::REG_CLK_SEL: rd_word = clk_sel_q;
      igoe_pkg::REG_GUARD_CFG: rd_word = guard_word;
      igoe_pkg::REG_PIN_BYPASS: rd_word = pin_bypass_q;
      igoe_pkg::REG_GOE_CFG: rd_word = goe_cfg_q;
      igoe_pkg::REG_OSC_CFG: rd_word = osc_word;
      igoe_pkg::REG_DIV_FACTOR: rd_word = div_factor_q;
      igoe_pkg::REG_DED_GUARD: rd_word = {16'h0, ded_guard_q};
      igoe_pkg::REG_STATUS: rd_word = {17'h0, divided_clock_out_o, osc_clock_out_o,
                                       osc_stop, global_output_enable_o,
                                       goe_term_bus, block_input_enable};
      default: begin
        rd_word = igoe_pkg::RST_ZERO;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= igoe_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? igoe_pkg::RESP_OKAY : igoe_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Guarded pin must not change while its enable is off.
  a_pin_hold_guard: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (guard_cfg_q.guard_en[0] && !pin_bypass_q[0] && !block_input_enable[0])
      |=> $stable(routing_pin_o[0])) else $error("guarded pin changed while disabled");
  a_pin_pass_open: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pin_bypass_q[0] |=> routing_pin_o[0] == $past(pin_s2_q[0]))
    else $error("bypassed pin did not follow input");
  a_osc_stopped: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    osc_stop [*2] |-> $stable(osc_clock_out_o)) else $error("oscillator ran while stopped");
  a_goe_or_fuse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    goe_term_bus[0] == |(oe_product_term_i & {goe_cfg_q[12], goe_cfg_q[8],
                                                goe_cfg_q[4], goe_cfg_q[0]}))
    else $error("output enable term bus mismatch");
  a_goe_small_bus: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    goe_cfg_q[26] |=> global_output_enable_o[3:2] == 2'b00)
    else $error("upper enables active in two-bit mode");
  a_fb_mux_sel: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    osc_cfg_q.fb_sel[0] |=> macrocell_fb_o[0] == $past(osc_clock_out_o))
    else $error("feedback mux did not pick oscillator");
  a_div_reset: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (osc_cfg_q.div_rst_en && divider_reset_in_i) |=> !divided_clock_out_o && div_cnt_q == 0)
    else $error("divider not reset");
  a_ded_clk_map: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (ded_guard_q[1] && !block_input_enable[1]) |=> $stable(routing_clk_o[1]))
    else $error("clock input 1 not guarded by block B");

endmodule

// >>> verification/igoe_pin_model.sv
// Far side of the block: global clock pins and the external oscillator stop line.
module igoe_pin_model (
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic [3:0] gclk_val_i,
  input wire logic dis_i,
  output logic [3:0] gclk_pin_o,
  output logic osc_dynamic_disable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q = 5'h00;

  // Pins either hold a set pattern or free-run, pin k at the clock rate over 2 to the k+2.
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= cnt_q + 5'h01;
    gclk_pin_o <= run_i ? cnt_q[4:1] : gclk_val_i;
    osc_dynamic_disable_o <= dis_i;
  end
endmodule

// >>> verification/igoe_top_bench.sv
// Register-driven checks of clocks, input guarding, output enables and the oscillator.
module igoe_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, osc, divc, osc_dis;
  logic [1:0] bresp, rresp, fb_out, resp;
  logic [31:0] rdata, rpin, v;
  logic [31:0] io_pin = 32'h0000_0000;
  logic [5:0] ded_in = 6'h00;
  logic [3:0] bie_mc = 4'h0;
  logic [3:0] bie_ext = 4'h0;
  logic [3:0] pt = 4'h0;
  logic [3:0] gclk_val = 4'h0;
  logic [1:0] goe_pin = 2'h0;
  logic [1:0] fb_in = 2'h0;
  logic run = 1'h0;
  logic dis = 1'h0;
  logic div_rst = 1'h0;
  logic [3:0] gclk, rclk, global_output_enable;
  logic [15:0] lclk;
  logic [5:0] rded;
  logic [5:0] ded_mask [4] = '{6'h01, 6'h06, 6'h08, 6'h30};
  logic [31:0] goe_cfg [6] = '{32'h0000_8421, 32'h0000_FFFF, 32'h000F_8421,
                              32'h00C0_8421, 32'h00F0_8421, 32'h0400_FFFF};
  logic [9:0] goe_vec [6] = '{10'h145, 10'h10F, 10'h14A, 10'h166, 10'h165, 10'h3C3};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int p;
  int n;

  igoe_top igoe_top_inst (
    .clk_sys_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gclk_pin_i(gclk), .io_pin_i(io_pin), .ded_in_i(ded_in), .bie_macrocell_i(bie_mc),
    .bie_ext_pin_i(bie_ext), .oe_product_term_i(pt), .goe_pin_i(goe_pin),
    .macrocell_fb_i(fb_in), .divider_reset_in_i(div_rst), .osc_dynamic_disable_i(osc_dis),
    .logic_block_clk_o(lclk), .routing_clk_o(rclk), .routing_pin_o(rpin),
    .routing_ded_o(rded), .global_output_enable_o(global_output_enable), .osc_clock_out_o(osc),
    .divided_clock_out_o(divc), .macrocell_fb_o(fb_out)
  );

  igoe_pin_model igoe_pin_model_inst (
    .clk_sys_i(clk), .run_i(run), .gclk_val_i(gclk_val), .dis_i(dis),
    .gclk_pin_o(gclk), .osc_dynamic_disable_o(osc_dis)
  );

  // Free-running system clock.
  initial begin
    forever #4 clk = ~clk;
  end

  // Compares a value seen against the one expected and counts both.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write with address and data offered together; each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd, na, nw;
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge clk);
      na = !ad && awready;
      nw = !wd && wready;
      @(posedge clk);
      if (na) awvalid <= 1'h0;
      if (nw) wvalid <= 1'h0;
      ad = ad | na;
      wd = wd | nw;
    end
    do @(negedge clk); while (bvalid !== 1'h1);
    r = bresp;
    @(posedge clk);
    bready <= 1'h0;
    @(posedge clk);
  endtask

  // Read: address held until taken, ready held until the data is sampled.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk); while (arready !== 1'h1);
    @(posedge clk);
    arvalid <= 1'h0;
    do @(negedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
    @(posedge clk);
  endtask

  // Cycles between two rising edges of the oscillator (s = 0) or the divider (s = 1).
  task automatic period(input logic s, output int q);
    logic prev, cur;
    int k;
    q = 0;
    k = 0;
    prev = s ? divc : osc;
    while (k < 2) begin
      @(negedge clk);
      cur = s ? divc : osc;
      if (k == 1) q++;
      if (cur && !prev) k++;
      prev = cur;
    end
    @(posedge clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hung run short; the whole sequence needs well under this many cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // Reset values and an unmapped address.
    rd(igoe_pkg::REG_CLK_SEL, v, resp);
    chk("clk_sel", v, igoe_pkg::RST_CLK_SEL);
    rd(igoe_pkg::REG_DIV_FACTOR, v, resp);
    chk("div_factor", v, igoe_pkg::DIV_FACTOR_DEFAULT);
    rd(8'h40, v, resp);
    chk("unmapped read", {v[29:0], resp}, {30'h0000_0000, igoe_pkg::RESP_SLVERR});
    wr(8'h40, 32'hFFFF_FFFF, resp);
    chk("unmapped write", 32'(resp), 32'(igoe_pkg::RESP_SLVERR));
    // Static pin pattern reaches every block's local clocks and the routing pool.
    gclk_val <= 4'h5;
    repeat (6) @(posedge clk);
    chk("local clocks", 32'(lclk), 32'h0000_5555);
    chk("routing clocks", 32'(rclk), 32'h0000_0005);
    // Blocks A and C take pin k inverted, blocks B and D pin k true.
    wr(igoe_pkg::REG_CLK_SEL, 32'h3210_7654, resp);
    repeat (2) @(posedge clk);
    chk("inverted clocks", 32'(lclk), 32'h0000_5A5A);
    // Block A guarded by its fabric enable; block B unguarded.
    wr(igoe_pkg::REG_GUARD_CFG, 32'h0000_0001, resp);
    bie_mc <= 4'h1;
    io_pin <= 32'h0000_00A5;
    repeat (6) @(posedge clk);
    chk("pins enabled", rpin, 32'h0000_00A5);
    bie_mc <= 4'h0;
    repeat (2) @(posedge clk);
    io_pin <= 32'h0000_3C5A;
    repeat (6) @(posedge clk);
    chk("pins held", rpin, 32'h0000_3CA5);
    wr(igoe_pkg::REG_PIN_BYPASS, 32'h0000_0001, resp);
    repeat (6) @(posedge clk);
    chk("pin bypass", rpin, 32'h0000_3CA4);
    wr(igoe_pkg::REG_GUARD_CFG, 32'h0000_0011, resp);
    bie_ext <= 4'h1;
    repeat (8) @(posedge clk);
    chk("external enable", rpin, 32'h0000_3C5A);
    // Each block enable alone opens only its assigned dedicated inputs and clocks.
    wr(igoe_pkg::REG_GUARD_CFG, 32'h0000_000F, resp);
    wr(igoe_pkg::REG_DED_GUARD, 32'h0000_03FF, resp);
    for (int b = 0; b < 4; b++) begin
      bie_mc <= 4'hF;
      ded_in <= 6'h00;
      gclk_val <= 4'h0;
      repeat (8) @(posedge clk);
      bie_mc <= 4'h1 << b;
      repeat (2) @(posedge clk);
      ded_in <= 6'h3F;
      gclk_val <= 4'hF;
      repeat (8) @(posedge clk);
      chk("dedicated inputs", 32'(rded), 32'(ded_mask[b]));
      chk("dedicated clocks", 32'(rclk), 32'h1 << b);
    end
    wr(igoe_pkg::REG_DED_GUARD, 32'h0000_0000, resp);
    // Output enable bus: fuses, inversions, pin sources and two-bit mode.
    for (int i = 0; i < 6; i++) begin
      wr(igoe_pkg::REG_GOE_CFG, goe_cfg[i], resp);
      pt <= goe_vec[i][9:6];
      goe_pin <= goe_vec[i][5:4];
      repeat (6) @(posedge clk);
      chk("global oe", 32'(global_output_enable), 32'(goe_vec[i][3:0]));
    end
    // Oscillator and divider with a factor of two.
    wr(igoe_pkg::REG_DIV_FACTOR, 32'h0000_0002, resp);
    wr(igoe_pkg::REG_OSC_CFG, 32'h0000_0010, resp);
    fb_in <= 2'h2;
    period(1'h0, p);
    chk("osc period", 32'(p), 32'h0000_0018);
    period(1'h1, p);
    chk("divider period", 32'(p), 32'h0000_0030);
    chk("feedback", 32'(fb_out), 32'h0000_0002);
    wr(igoe_pkg::REG_OSC_CFG, 32'h0000_0014, resp);
    div_rst <= 1'h1;
    repeat (60) @(posedge clk);
    chk("divider reset", 32'(divc), 32'h0000_0000);
    div_rst <= 1'h0;
    wr(igoe_pkg::REG_OSC_CFG, 32'h0000_001B, resp);
    dis <= 1'h1;
    repeat (10) @(posedge clk);
    v[0] = osc;
    n = 0;
    repeat (60) begin
      @(negedge clk);
      if (osc !== v[0]) n++;
    end
    chk("osc stopped", 32'(n), 32'h0000_0000);
    chk("feedback osc", 32'(fb_out), 32'({divc, osc}));
    @(posedge clk);
    dis <= 1'h0;
    period(1'h0, p);
    chk("osc restart", 32'(p), 32'h0000_0018);
    results();
  end
endmodule
